// ===== core/thr_pkg.sv
`default_nettype none
package thr_pkg;
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int POR_HOLD_MS = 16;
   localparam int POR_HOLD_CYC = POR_HOLD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SCLK_MIN_PERIOD_US = 8;
   localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_US * 1000 + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   // Frame layout
   localparam int CMD_BITS = 32;
   localparam int OP_BITS = 8;
   localparam int ADDR_BITS = 8;
   localparam int DATA_BITS = 16;
   localparam int ECHO_DELAY = 8;
   localparam int ECHO_CHECK_EDGE = 24;
   localparam int READ_DATA_EDGE = 25;
   localparam int READ_FRAME = 40;
   localparam int SAMPLE_BITS = 12;
   // Register addresses
   localparam logic [7:0] ADDR_CMP1_CFG = 8'h00;
   localparam logic [7:0] ADDR_CMP2_CFG = 8'h01;
   localparam logic [7:0] ADDR_OBJECT = 8'h09;
   localparam logic [7:0] ADDR_AMBIENT = 8'h0a;
   // Comparator configuration fields
   localparam int CFG_SRC_BIT = 0;
   localparam int CFG_INV_BIT = 1;
   localparam int CFG_HYS_LSB = 4;
   localparam logic [15:0] CMP_CFG_RESET = 16'h0002;
   // Nonvolatile memory
   localparam int NVM_WORDS = 64;
   localparam int NVM_ADDR_BITS = 6;
   localparam logic [5:0] NVM_THR1 = 6'h00;
   localparam logic [5:0] NVM_THR2 = 6'h01;
   localparam logic [5:0] NVM_AMB_CAL = 6'h02;
   localparam logic [5:0] NVM_OBJ_CAL = 6'h03;
   localparam logic [15:0] NVM_ERASED = 16'h0000;
   // Opcode patterns: care mask and value
   localparam logic [7:0] OPM_REG_WR = 8'h74;
   localparam logic [7:0] OPV_REG_WR = 8'h50;
   localparam logic [7:0] OPM_REG_RD = 8'h7c;
   localparam logic [7:0] OPV_REG_RD = 8'h48;
   localparam logic [7:0] OPM_NVM_WR = 8'hf0;
   localparam logic [7:0] OPV_NVM_WR = 8'h10;
   localparam logic [7:0] OPM_NVM_ER = 8'he0;
   localparam logic [7:0] OPV_NVM_ER = 8'h20;
   localparam logic [7:0] OPM_NVM_RD = 8'h78;
   localparam logic [7:0] OPV_NVM_RD = 8'h08;
   localparam logic [7:0] OPM_BLK_WR = 8'hf0;
   localparam logic [7:0] OPV_BLK_WR = 8'h90;
   localparam logic [7:0] OPM_BLK_ER = 8'he0;
   localparam logic [7:0] OPV_BLK_ER = 8'ha0;
   // Host register map
   localparam logic [4:0] WB_CMD = 5'h00;
   localparam logic [4:0] WB_CTRL = 5'h04;
   localparam logic [4:0] WB_STATUS = 5'h08;
   localparam logic [4:0] WB_RX_LO = 5'h0c;
   localparam logic [4:0] WB_RX_HI = 5'h10;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int CTRL_CHECK_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ABORT_BIT = 2;

   typedef enum logic [2:0] {
      OP_NONE, OP_REG_WR, OP_REG_RD, OP_NVM_WR, OP_NVM_ER, OP_NVM_RD, OP_BLK_WR, OP_BLK_ER
   } thr_op_t;
   typedef enum logic [1:0] {LIN_IDLE = 2'b00, LIN_AMB = 2'b01, LIN_OBJ = 2'b11} thr_lin_t;
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_SHIFT = 2'b01, H_END = 2'b11} thr_host_t;

   function automatic thr_op_t thr_decode(input logic [7:0] op);
      thr_op_t res;
      res = OP_NONE;
      if ((op & OPM_REG_WR) == OPV_REG_WR) res = OP_REG_WR;
      else if ((op & OPM_REG_RD) == OPV_REG_RD) res = OP_REG_RD;
      else if ((op & OPM_NVM_WR) == OPV_NVM_WR) res = OP_NVM_WR;
      else if ((op & OPM_NVM_ER) == OPV_NVM_ER) res = OP_NVM_ER;
      else if ((op & OPM_NVM_RD) == OPV_NVM_RD) res = OP_NVM_RD;
      else if ((op & OPM_BLK_WR) == OPV_BLK_WR) res = OP_BLK_WR;
      else if ((op & OPM_BLK_ER) == OPV_BLK_ER) res = OP_BLK_ER;
      return res;
   endfunction : thr_decode
endpackage : thr_pkg
`default_nettype wire

// ===== core/thr_link_if.sv
`default_nettype none
interface thr_link_if;
   logic sclk;
   logic selectN;
   logic serialIn;
   logic serialOut;
   modport device (input sclk, input selectN, input serialIn, output serialOut);
   modport host (output sclk, output selectN, output serialIn, input serialOut);
endinterface : thr_link_if
`default_nettype wire

// ===== core/thr_comparator.sv
`default_nettype none
module thr_comparator (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Settings and input
   input wire logic [thr_pkg::SAMPLE_BITS-1:0] value,
   input wire logic [thr_pkg::SAMPLE_BITS-1:0] threshold,
   input wire logic [thr_pkg::SAMPLE_BITS-1:0] hysteresis,
   input wire logic invert,
   // Output
   output logic out
);
   import thr_pkg::*;
   logic trip_ff;
   logic out_ff;
   logic [SAMPLE_BITS:0] upper;
   logic [SAMPLE_BITS:0] lower;

   assign upper = {1'b0, threshold} + {1'b0, hysteresis};
   assign lower = (threshold > hysteresis) ? {1'b0, threshold - hysteresis} : '0;

   // Band around the threshold
   always_ff @(posedge core_clk) begin
      if (rst) begin
         trip_ff <= 1'b0;
      end else if ({1'b0, value} >= upper) begin
         trip_ff <= 1'b1;
      end else if ({1'b0, value} <= lower) begin
         trip_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_ff <= 1'b0;
      end else begin
         out_ff <= trip_ff ^ invert;
      end
   end

   assign out = out_ff;
endmodule : thr_comparator
`default_nettype wire

// ===== core/thr_device.sv
// Operation
// - Commands are 8 opcode, 8 address, 16 data
// - Device is slave, never drives clock/select
// - Master frames write with select low, 32 clocks
// - Sample serial input on rising clock edges
// - Write echo delayed by eight clock periods
// - Early select rise abandons the command
// - Read echoes opcode, then data, no address
// - Read data starts at 25th rising edge
// - Master captures output on rising edges
// - Master clock period at least 8 us
// - Decode register write and read opcodes
// - Decode single-word memory write/erase/read
// - Reach memory and registers; block write/erase
// - Object at 09h, ambient at 0Ah, readable
// - Power-on reset holds logic 16 ms
// - Comparators select source, hysteresis, polarity
// - Comparator one drives relay, memory threshold
// - Comparator two drives ambient pin
// - Ambient computed first, then object temperature
// - Sensor samples are 12-bit
// - Comparators compare at 12-bit resolution
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
module thr_device #(
   parameter int POR_HOLD = thr_pkg::POR_HOLD_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Serial link
   thr_link_if.device link,
   // Supply monitor and sensor samples
   input wire logic supplyOk,
   input wire logic sampleValid,
   input wire logic [thr_pkg::SAMPLE_BITS-1:0] thermistorSample,
   input wire logic [thr_pkg::SAMPLE_BITS-1:0] irSample,
   // Outputs
   output logic relayDriveOut,
   output logic ambientOutPin,
   output logic operational
);
   import thr_pkg::*;

   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   logic sclkPrev_ff;
   logic supplyMeta_ff;
   logic supplySync_ff;
   logic [31:0] porCnt_ff;
   logic operational_ff;
   logic intRst;
   logic sclkRise;
   logic sclkFall;
   logic selActive;
   logic selPrev_ff;
   logic [5:0] bitCnt_ff;
   logic [CMD_BITS-1:0] rx_ff;
   thr_op_t op_ff;
   logic [DATA_BITS-1:0] rdShift_ff;
   logic [DATA_BITS-1:0] rdWord;
   logic [ADDR_BITS-1:0] addrNow;
   logic isRead;
   logic doExec;
   logic serialOut_ff;
   logic [15:0] cmp1Cfg_ff;
   logic [15:0] cmp2Cfg_ff;
   logic [15:0] nvm_ff [NVM_WORDS];
   logic [15:0] object_ff;
   logic [15:0] ambient_ff;
   logic [SAMPLE_BITS-1:0] thermS_ff;
   logic [SAMPLE_BITS-1:0] irS_ff;
   thr_lin_t linState_ff;

   // Pin synchronisers; clock and select are only ever read
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_ff <= 3'b010;
         sync_ff <= 3'b010;
         sclkPrev_ff <= 1'b0;
         supplyMeta_ff <= 1'b0;
         supplySync_ff <= 1'b0;
      end else begin
         meta_ff <= {link.sclk, link.selectN, link.serialIn};
         sync_ff <= meta_ff;
         sclkPrev_ff <= sync_ff[2];
         supplyMeta_ff <= supplyOk;
         supplySync_ff <= supplyMeta_ff;
      end
   end

   assign sclkRise = sync_ff[2] & ~sclkPrev_ff;
   assign sclkFall = ~sync_ff[2] & sclkPrev_ff;
   assign selActive = ~sync_ff[1];

   // Power-on hold
   always_ff @(posedge core_clk) begin
      if (rst || !supplySync_ff) begin
         porCnt_ff <= '0;
         operational_ff <= 1'b0;
      end else if (porCnt_ff == 32'(POR_HOLD - 1)) begin
         operational_ff <= 1'b1;
      end else begin
         porCnt_ff <= porCnt_ff + 32'd1;
      end
   end

   assign intRst = ~operational_ff;
   assign operational = operational_ff;

   // Frame reception
   always_ff @(posedge core_clk) begin
      if (intRst || !selActive) begin
         bitCnt_ff <= '0;
      end else if (sclkRise && bitCnt_ff != 6'(READ_FRAME)) begin
         bitCnt_ff <= bitCnt_ff + 6'd1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (intRst) begin
         rx_ff <= '0;
      end else if (selActive && sclkRise) begin
         rx_ff <= {rx_ff[CMD_BITS-2:0], sync_ff[0]};
      end
   end

   always_ff @(posedge core_clk) begin
      selPrev_ff <= intRst ? 1'b0 : selActive;
   end

   always_ff @(posedge core_clk) begin
      if (intRst || !selActive) begin
         op_ff <= OP_NONE;
      end else if (sclkRise && bitCnt_ff == 6'(OP_BITS - 1)) begin
         op_ff <= thr_decode({rx_ff[OP_BITS-2:0], sync_ff[0]});
      end
   end

   // Read data
   assign addrNow = {rx_ff[ADDR_BITS-2:0], sync_ff[0]};
   assign isRead = (op_ff == OP_REG_RD) || (op_ff == OP_NVM_RD);

   always_comb begin
      rdWord = '0;
      if (op_ff == OP_NVM_RD) begin
         rdWord = nvm_ff[addrNow[NVM_ADDR_BITS-1:0]];
      end else begin
         case (addrNow)
            ADDR_OBJECT: rdWord = object_ff;
            ADDR_AMBIENT: rdWord = ambient_ff;
            ADDR_CMP1_CFG: rdWord = cmp1Cfg_ff;
            ADDR_CMP2_CFG: rdWord = cmp2Cfg_ff;
            default: rdWord = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (intRst || !selActive) begin
         rdShift_ff <= '0;
      end else if (sclkRise && isRead && bitCnt_ff == 6'(OP_BITS + ADDR_BITS - 1)) begin
         rdShift_ff <= rdWord;
      end else if (sclkFall && isRead && bitCnt_ff >= 6'(READ_DATA_EDGE - 1)) begin
         rdShift_ff <= {rdShift_ff[DATA_BITS-2:0], 1'b0};
      end
   end

   // Output changes on falling edges, stable at the rising edge
   always_ff @(posedge core_clk) begin
      if (intRst || !selActive) begin
         serialOut_ff <= 1'b0;
      end else if (sclkFall) begin
         if (isRead && bitCnt_ff >= 6'(READ_DATA_EDGE - 1)) begin
            serialOut_ff <= rdShift_ff[DATA_BITS-1];
         end else if (isRead && bitCnt_ff >= 6'(OP_BITS + ECHO_DELAY)) begin
            serialOut_ff <= 1'b0;
         end else if (bitCnt_ff >= 6'(ECHO_DELAY)) begin
            serialOut_ff <= rx_ff[ECHO_DELAY-1];
         end
      end
   end

   assign link.serialOut = serialOut_ff;

   // Command runs only when select rises after exactly a full frame
   assign doExec = selPrev_ff && !selActive && bitCnt_ff == 6'(CMD_BITS);

   always_ff @(posedge core_clk) begin
      if (intRst) begin
         cmp1Cfg_ff <= CMP_CFG_RESET;
         cmp2Cfg_ff <= CMP_CFG_RESET;
      end else if (doExec && op_ff == OP_REG_WR) begin
         case (rx_ff[23:16])
            ADDR_CMP1_CFG: cmp1Cfg_ff <= rx_ff[15:0];
            ADDR_CMP2_CFG: cmp2Cfg_ff <= rx_ff[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < NVM_WORDS; i++) begin
            nvm_ff[i] <= NVM_ERASED;
         end
      end else if (doExec) begin
         case (op_ff)
            OP_NVM_WR: nvm_ff[rx_ff[16 +: NVM_ADDR_BITS]] <= rx_ff[15:0];
            OP_NVM_ER: nvm_ff[rx_ff[16 +: NVM_ADDR_BITS]] <= NVM_ERASED;
            OP_BLK_WR: begin
               for (int i = 0; i < NVM_WORDS; i++) begin
                  nvm_ff[i] <= rx_ff[15:0];
               end
            end
            OP_BLK_ER: begin
               for (int i = 0; i < NVM_WORDS; i++) begin
                  nvm_ff[i] <= NVM_ERASED;
               end
            end
            default: ;
         endcase
      end
   end

   // Linearisation: ambient first, then object
   always_ff @(posedge core_clk) begin
      if (intRst) begin
         linState_ff <= LIN_IDLE;
         thermS_ff <= '0;
         irS_ff <= '0;
         ambient_ff <= '0;
         object_ff <= '0;
      end else begin
         case (linState_ff)
            LIN_IDLE: begin
               if (sampleValid) begin
                  thermS_ff <= thermistorSample;
                  irS_ff <= irSample;
                  linState_ff <= LIN_AMB;
               end
            end
            LIN_AMB: begin
               ambient_ff <= {4'h0, thermS_ff + nvm_ff[NVM_AMB_CAL][SAMPLE_BITS-1:0]};
               linState_ff <= LIN_OBJ;
            end
            LIN_OBJ: begin
               object_ff <= {4'h0, irS_ff + ambient_ff[SAMPLE_BITS-1:0]
                  - nvm_ff[NVM_OBJ_CAL][SAMPLE_BITS-1:0]};
               linState_ff <= LIN_IDLE;
            end
            default: linState_ff <= LIN_IDLE;
         endcase
      end
   end

   // Comparators
   thr_comparator u_cmp1 (
      .core_clk(core_clk),
      .rst(intRst),
      .value(cmp1Cfg_ff[CFG_SRC_BIT] ? ambient_ff[SAMPLE_BITS-1:0] : object_ff[SAMPLE_BITS-1:0]),
      .threshold(nvm_ff[NVM_THR1][SAMPLE_BITS-1:0]),
      .hysteresis(cmp1Cfg_ff[CFG_HYS_LSB +: SAMPLE_BITS]),
      .invert(cmp1Cfg_ff[CFG_INV_BIT]),
      .out(relayDriveOut)
   );

   thr_comparator u_cmp2 (
      .core_clk(core_clk),
      .rst(intRst),
      .value(cmp2Cfg_ff[CFG_SRC_BIT] ? ambient_ff[SAMPLE_BITS-1:0] : object_ff[SAMPLE_BITS-1:0]),
      .threshold(nvm_ff[NVM_THR2][SAMPLE_BITS-1:0]),
      .hysteresis(cmp2Cfg_ff[CFG_HYS_LSB +: SAMPLE_BITS]),
      .invert(cmp2Cfg_ff[CFG_INV_BIT]),
      .out(ambientOutPin)
   );
endmodule : thr_device
`default_nettype wire

// ===== core/thr_host.sv
`default_nettype none
module thr_host (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Serial link
   thr_link_if.host link
);
   import thr_pkg::*;

   logic ack_ff;
   logic [31:0] datOut_ff;
   logic [31:0] cmd_ff;
   logic ctrlRead_ff;
   logic ctrlCheck_ff;
   logic busy_ff;
   logic done_ff;
   logic abort_ff;
   logic [39:0] rx_ff;
   logic [31:0] txShift_ff;
   logic [5:0] cnt_ff;
   logic [15:0] div_ff;
   logic sclk_ff;
   logic selectN_ff;
   logic serialIn_ff;
   logic soMeta_ff;
   logic soSync_ff;
   thr_host_t state_ff;
   logic wbReq;
   logic wbWr;
   logic start;
   logic tick;
   logic mismatch;
   logic [5:0] frameLen;

   assign wbReq = wb_cyc_i & wb_stb_i;
   assign wbWr = wbReq & wb_we_i & ack_ff;
   assign start = wbWr && wb_adr_i == WB_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START_BIT] && !busy_ff;

   // Bus answer one cycle after the request
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ack_ff <= 1'b0;
         datOut_ff <= '0;
      end else begin
         ack_ff <= wbReq & ~ack_ff;
         if (wbReq && !ack_ff) begin
            case (wb_adr_i)
               WB_CMD: datOut_ff <= cmd_ff;
               WB_CTRL: datOut_ff <= {29'h0000_0000, ctrlCheck_ff, ctrlRead_ff, 1'b0};
               WB_STATUS: datOut_ff <= {29'h0000_0000, abort_ff, done_ff, busy_ff};
               WB_RX_LO: datOut_ff <= rx_ff[31:0];
               WB_RX_HI: datOut_ff <= {24'h00_0000, rx_ff[39:32]};
               default: datOut_ff <= '0;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = datOut_ff;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cmd_ff <= '0;
         ctrlRead_ff <= 1'b0;
         ctrlCheck_ff <= 1'b0;
      end else if (wbWr && !busy_ff) begin
         if (wb_adr_i == WB_CMD) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) cmd_ff[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end else if (wb_adr_i == WB_CTRL && wb_sel_i[0]) begin
            ctrlRead_ff <= wb_dat_i[CTRL_READ_BIT];
            ctrlCheck_ff <= wb_dat_i[CTRL_CHECK_BIT];
         end
      end
   end

   // Serial output synchroniser
   always_ff @(posedge core_clk) begin
      soMeta_ff <= rst ? 1'b0 : link.serialOut;
      soSync_ff <= rst ? 1'b0 : soMeta_ff;
   end

   // Half-period divider
   always_ff @(posedge core_clk) begin
      if (rst || state_ff == H_IDLE || tick) begin
         div_ff <= '0;
      end else begin
         div_ff <= div_ff + 16'd1;
      end
   end

   assign tick = div_ff == 16'(SCLK_HALF_CYC - 1);
   assign frameLen = ctrlRead_ff ? 6'(READ_FRAME) : 6'(CMD_BITS);
   assign mismatch = ctrlRead_ff ? (rx_ff[15:8] != cmd_ff[31:24]) : (rx_ff[15:0] != cmd_ff[31:16]);

   // Frame sequencer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= H_IDLE;
         sclk_ff <= 1'b0;
         selectN_ff <= 1'b1;
         serialIn_ff <= 1'b0;
         txShift_ff <= '0;
         rx_ff <= '0;
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
         abort_ff <= 1'b0;
      end else begin
         if (wbWr && wb_adr_i == WB_STATUS && wb_sel_i[0]) begin
            if (wb_dat_i[STAT_DONE_BIT]) done_ff <= 1'b0;
            if (wb_dat_i[STAT_ABORT_BIT]) abort_ff <= 1'b0;
         end
         case (state_ff)
            H_IDLE: begin
               if (start) begin
                  selectN_ff <= 1'b0;
                  sclk_ff <= 1'b0;
                  serialIn_ff <= cmd_ff[31];
                  txShift_ff <= {cmd_ff[30:0], 1'b0};
                  rx_ff <= '0;
                  cnt_ff <= '0;
                  busy_ff <= 1'b1;
                  state_ff <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick && !sclk_ff) begin
                  sclk_ff <= 1'b1;
                  rx_ff <= {rx_ff[38:0], soSync_ff};
                  cnt_ff <= cnt_ff + 6'd1;
               end else if (tick) begin
                  sclk_ff <= 1'b0;
                  if (cnt_ff == frameLen) begin
                     state_ff <= H_END;
                  end else if (ctrlCheck_ff && cnt_ff == 6'(ECHO_CHECK_EDGE) && mismatch) begin
                     abort_ff <= 1'b1;
                     state_ff <= H_END;
                  end else begin
                     serialIn_ff <= txShift_ff[31];
                     txShift_ff <= {txShift_ff[30:0], 1'b0};
                  end
               end
            end
            H_END: begin
               if (tick) begin
                  selectN_ff <= 1'b1;
                  busy_ff <= 1'b0;
                  done_ff <= 1'b1;
                  state_ff <= H_IDLE;
               end
            end
            default: state_ff <= H_IDLE;
         endcase
      end
   end

   assign link.sclk = sclk_ff;
   assign link.selectN = selectN_ff;
   assign link.serialIn = serialIn_ff;
endmodule : thr_host
`default_nettype wire

// ===== tb/thr_link_monitor.sv
`default_nettype none
module thr_link_monitor
   import thr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Serial link
   input wire logic sclk,
   input wire logic selectN,
   input wire logic serialIn,
   input wire logic serialOut
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   int rises;
   logic [7:0] hist;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Cycles since last link edge, rises in frame, last received bits
   always_ff @(posedge core_clk) begin
      cnt <= (rst || $changed(sclk) || $changed(selectN)) ? 0 : cnt + 1;
      rises <= (rst || $fell(selectN)) ? 0 : rises + int'($rose(sclk));
      if ($rose(sclk) && !selectN) begin
         hist <= {hist[6:0], serialIn};
      end
   end
   a_out_idle_low: assert property (selectN [*8] |-> !serialOut) else $error("out not low");
   a_out_steady: assert property ($rose(sclk) && !selectN |-> $stable(serialOut) [*2]) else $error("out moved");
   a_out_on_low: assert property ($changed(serialOut) && !selectN |-> !sclk) else $error("out edge");
   a_sclk_idle: assert property (selectN |-> !sclk) else $error("clock not idle");
   a_in_steady: assert property ($rose(sclk) && !selectN |-> $stable(serialIn)) else $error("in moved");
   a_half_period: assert property ($changed(sclk) && !selectN |-> cnt == SCLK_HALF_CYC - 1) else $error("period");
   a_frame_len: assert property ($rose(selectN) |-> rises inside {CMD_BITS, READ_FRAME, ECHO_CHECK_EDGE})
      else $error("frame length");
   a_start_quiet: assert property ($fell(selectN) |-> !sclk [*8]) else $error("early clock");
   a_opcode_echo: assert property ($rose(sclk) && !selectN && rises >= 8 && rises < 16 |-> serialOut == hist[7])
      else $error("opcode echo");
   c_read_frame: cover property ($rose(selectN) && rises == READ_FRAME);
   c_write_frame: cover property ($rose(selectN) && rises == CMD_BITS);
   c_echo_bit: cover property ($rose(sclk) && rises == 8);
endmodule : thr_link_monitor
`default_nettype wire

// ===== tb/thermometer_spi_command_slave_tb_top.sv
`default_nettype none
module thermometer_spi_command_slave_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import thr_pkg::*;
   localparam int POR = 20;
   localparam int RF = READ_FRAME;
   localparam int WF = CMD_BITS;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic supplyOk = 1'b1;
   logic sampleValid = 1'b0;
   logic [11:0] therm = 12'h000;
   logic [11:0] ir = 12'h000;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [39:0] rx;
   logic ack, op1, op2, rel, amo;
   int err_count = 0;
   int n_checks = 0;
   int nvm[64];
   int amb, obj;
   thr_link_if l1 ();
   thr_link_if l2 ();
   always #2 core_clk = ~core_clk;
   thr_host u_thr_host (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(l1.host));
   thr_device #(.POR_HOLD(POR)) u_thr_device (.core_clk(core_clk), .rst(rst), .link(l1.device),
      .supplyOk(supplyOk), .sampleValid(sampleValid), .thermistorSample(therm), .irSample(ir),
      .relayDriveOut(), .ambientOutPin(), .operational(op1));
   thr_device #(.POR_HOLD(POR)) u_thr_device_2 (.core_clk(core_clk), .rst(rst), .link(l2.device),
      .supplyOk(supplyOk), .sampleValid(sampleValid), .thermistorSample(therm), .irSample(ir),
      .relayDriveOut(rel), .ambientOutPin(amo), .operational(op2));
   thr_link_monitor u_thr_link_monitor (.core_clk(core_clk), .rst(rst), .sclk(l1.sclk),
      .selectN(l1.selectN), .serialIn(l1.serialIn), .serialOut(l1.serialOut));
   task automatic end_of_test();
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   task automatic tmo();
      err_count++;
      end_of_test();
   endtask : tmo
   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (ack === 1'b1) break;
      end
      if (i == 50) tmo();
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask : wb
   task automatic waitOp(output int k);
      for (k = 0; k < 200 && (op1 !== 1'b1 || op2 !== 1'b1); k++) @(posedge core_clk);
      if (k == 200) tmo();
   endtask : waitOp
   task automatic sample();
      therm <= 12'($urandom);
      ir <= 12'($urandom);
      sampleValid <= 1'b1;
      @(posedge core_clk);
      sampleValid <= 1'b0;
      repeat (4) @(posedge core_clk);
      amb = (therm + nvm[2]) & 4095;
      obj = (ir + amb - nvm[3]) & 4095;
   endtask : sample
   // Bench acts as serial master on the second link, 80 ns clock
   task automatic frame(input logic [31:0] c, input int n);
      rx = '0;
      l2.selectN <= 1'b0;
      l2.serialIn <= c[31];
      for (int i = 1; i <= n; i++) begin
         repeat (10) @(posedge core_clk);
         l2.sclk <= 1'b1;
         rx = {rx[38:0], l2.serialOut};
         repeat (10) @(posedge core_clk);
         l2.sclk <= 1'b0;
         l2.serialIn <= (i < 32) ? c[31-i] : !l2.serialIn;
      end
      repeat (10) @(posedge core_clk);
      l2.selectN <= 1'b1;
      repeat (20) @(posedge core_clk);
   endtask : frame
   task automatic cmd(input logic [7:0] op, input logic [7:0] a, input logic [15:0] d, input int n);
      frame({op, a, d}, n);
      if (n == WF) chk("echo", {op, a, d[15:8]}, rx[23:0]);
      if (n == RF) chk("read", {op, 8'h00, d}, rx[31:0]);
   endtask : cmd
   initial begin
      logic [31:0] q;
      logic [15:0] d;
      int k;
      void'($urandom(54));
      l2.sclk = 1'b0;
      l2.selectN = 1'b1;
      l2.serialIn = 1'b0;
      nvm = '{default: 0};
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      waitOp(k);
      supplyOk <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk("operational", 0, op2);
      supplyOk <= 1'b1;
      waitOp(k);
      chk("hold", 1, k >= POR && k <= POR + 8);
      sample();
      wb(1'b1, WB_CMD, {OPV_REG_RD, ADDR_AMBIENT, 16'h0000}, q);
      wb(1'b1, WB_CTRL, 32'h0000_0007, q);
      for (k = 0; k < 40000; k++) begin
         wb(1'b0, WB_STATUS, 32'h0000_0000, q);
         if (q[STAT_DONE_BIT] === 1'b1) break;
      end
      if (k == 40000) tmo();
      chk("abort", 0, q[STAT_ABORT_BIT]);
      wb(1'b0, WB_RX_LO, 32'h0000_0000, q);
      chk("hostRx", {OPV_REG_RD, 8'h00, 16'(amb)}, q);
      wb(1'b0, 5'h14, 32'h0000_0000, q);
      chk("unmapped", 0, q);
      cmd(8'hcb, ADDR_AMBIENT, 16'(amb), RF);
      cmd(8'h48, ADDR_OBJECT, 16'(obj), RF);
      cmd(8'h48, ADDR_CMP1_CFG, CMP_CFG_RESET, RF);
      d = 16'($urandom) & 16'hfff3;
      cmd(8'hd8, ADDR_CMP2_CFG, d, WF);
      chk("ambOut", ((d[0] ? amb : obj) == 0 && d[15:4] != 0) ? d[1] : !d[1], amo);
      cmd(8'h48, ADDR_CMP2_CFG, d, RF);
      cmd(8'h50, ADDR_OBJECT, d, WF);
      cmd(8'h48, ADDR_OBJECT, 16'(obj), RF);
      nvm[2] = 16'($urandom);
      cmd(8'h1f, 8'h02, 16'(nvm[2]), WF);
      cmd(8'h1f, 8'h03, d, 20);
      cmd(8'h1f, 8'h03, d, 33);
      cmd(8'h00, 8'h03, d, WF);
      cmd(8'h8f, 8'h03, 16'h0000, RF);
      cmd(8'h8f, 8'h02, 16'(nvm[2]), RF);
      sample();
      cmd(8'h48, ADDR_AMBIENT, 16'(amb), RF);
      nvm[3] = d;
      cmd(8'h1f, 8'h03, d, WF);
      cmd(8'h3a, 8'h02, 16'h0000, WF);
      nvm[2] = 0;
      sample();
      cmd(8'h48, ADDR_OBJECT, 16'(obj), RF);
      cmd(8'h9c, 8'h03, d, WF);
      chk("relay", obj >= (d & 16'h0fff) ? 0 : 1, rel);
      cmd(8'h8f, 8'h05, d, RF);
      cmd(8'ha5, 8'h03, 16'h0000, WF);
      cmd(8'h8f, 8'h03, 16'h0000, RF);
      end_of_test();
   end
endmodule : thermometer_spi_command_slave_tb_top
`default_nettype wire
